/* design/slor_map.vh */
`ifndef SLOR_MAP_VH
`define SLOR_MAP_VH

// Register indices, byte address is four times the index
`define SLOR_IDX_EN 8'h73
`define SLOR_IDX_CHK12 8'h74
`define SLOR_IDX_CHK34 8'h75
`define SLOR_IDX_ID12 8'h76
`define SLOR_IDX_ID34 8'h77
`define SLOR_IDX_VER 8'h55
`define SLOR_IDX_STID12 8'h7A
`define SLOR_IDX_STID34 8'h7B
`define SLOR_IDX_STCHK12 8'h7C
`define SLOR_IDX_STCHK34 8'h7D
`define SLOR_IDX_STLINK 8'h7E

// Writable field masks, reserved bits read zero
`define SLOR_EN_MASK 16'hFF10
`define SLOR_CHK_MASK 16'hFFFF
`define SLOR_ID_MASK 16'h1F1F
`define SLOR_VER_MASK 16'hE0E0
`define SLOR_RESET_VAL 16'h0000

// Field positions
`define SLOR_IDEN_TOP 15
`define SLOR_CKEN_TOP 11
`define SLOR_UNLOCK_BIT 4
`define SLOR_HI_ID 12:8
`define SLOR_LO_ID 4:0
`define SLOR_HI_CHK 15:8
`define SLOR_LO_CHK 7:0
`define SLOR_SUB_FIELD 15:13
`define SLOR_VERS_FIELD 7:5
`define SLOR_FAULT_BIT 0

// Default lane identifiers
`define SLOR_DEF_ID1 5'h01
`define SLOR_DEF_ID2 5'h02
`define SLOR_DEF_ID3 5'h03
`define SLOR_DEF_ID4 5'h04

// Version and subclass codes
`define SLOR_SUB0 3'h0
`define SLOR_SUB1 3'h1
`define SLOR_SUB2 3'h2
`define SLOR_VER_A 3'h0
`define SLOR_VER_B 3'h1

// Bus encodings
`define SLOR_HSIZE_WORD 3'h2
`define SLOR_NONSEQ_BIT 1

`endif

/* design/slor_lane_sel.v */
`timescale 1ns/1ps
`default_nettype none
`include "slor_map.vh"

module slor_lane_sel (
    input wire ref_clk,
    input wire rst_n,
    input wire forceId,
    input wire forceChk,
    input wire [4:0] defaultId,
    input wire [4:0] forcedId,
    input wire [7:0] forcedChk,
    input wire [7:0] cfgSumBase,
    output reg [4:0] laneId,
    output reg [7:0] laneChk
);

    reg [4:0] next_laneId;
    reg [7:0] next_laneChk;

    always @*
    begin
        next_laneId = forceId ? forcedId : defaultId;
        // Own checksum over the lane's configuration
        next_laneChk = forceChk ? forcedChk : (cfgSumBase + {3'h0, next_laneId});
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            laneId <= defaultId;
            laneChk <= 8'h00;
        end
        else
        begin
            laneId <= next_laneId;
            laneChk <= next_laneChk;
        end
    end

endmodule
`default_nettype wire

/* design/slor_ver_dec.v */
`timescale 1ns/1ps
`default_nettype none
`include "slor_map.vh"

module slor_ver_dec (
    input wire ref_clk,
    input wire rst_n,
    input wire unlock,
    input wire [2:0] subclassSel,
    input wire [2:0] versionSel,
    output reg [2:0] linkSubclass,
    output reg [2:0] linkVersion,
    output reg versionFault
);

    reg [2:0] next_sub;
    reg [2:0] next_ver;
    reg next_fault;
    reg subOk;
    reg verOk;

    always @*
    begin
        subOk = (subclassSel == `SLOR_SUB0) || (subclassSel == `SLOR_SUB1) || (subclassSel == `SLOR_SUB2);
        verOk = (versionSel == `SLOR_VER_A) || (versionSel == `SLOR_VER_B);
        // Locked or bad code keeps the fixed mode
        if (unlock && subOk && verOk)
        begin
            next_sub = subclassSel;
            next_ver = versionSel;
            next_fault = 1'b0;
        end
        else
        begin
            next_sub = `SLOR_SUB1;
            next_ver = `SLOR_VER_B;
            next_fault = unlock;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            linkSubclass <= `SLOR_SUB1;
            linkVersion <= `SLOR_VER_B;
            versionFault <= 1'b0;
        end
        else
        begin
            linkSubclass <= next_sub;
            linkVersion <= next_ver;
            versionFault <= next_fault;
        end
    end

endmodule
`default_nettype wire

/* design/slor_regs.v */
// What this block does
// - Lane 1 sends ID 00001 and lane 2 sends 00010 unless forced.
// - Lane 3 sends ID 00011 and lane 4 sends 00100 unless forced.
// - Enable bits 15/14 force lane 1/2 IDs from identifier register bits 12-8/4-0.
// - Enable bits 13/12 force lane 3/4 IDs from second identifier register.
// - With checksum enable bits 11..8 clear, device computes each lane's checksum.
// - Forced checksum lane 1 from bits 15-8, lane 2 from 7-0.
// - Forced checksum lane 3 from bits 15-8, lane 4 from 7-0.
// - Unlock bit 4 clear fixes subclass 1 version B; set applies valid codes, bad codes keep subclass 1 version B and set the fault.
// - Subclass codes 000/001/010, version codes 000 A and 001 B.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "slor_map.vh"

module slor_regs (
    input wire ref_clk,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [7:0] cfgSumBase,
    output wire [19:0] laneIdent,
    output wire [31:0] laneChk,
    output wire [2:0] linkSubclass,
    output wire [2:0] linkVersion,
    output wire versionFault
);

    reg [15:0] enReg;
    reg [15:0] chk12;
    reg [15:0] chk34;
    reg [15:0] id12;
    reg [15:0] id34;
    reg [15:0] verReg;

    reg [15:0] next_enReg;
    reg [15:0] next_chk12;
    reg [15:0] next_chk34;
    reg [15:0] next_id12;
    reg [15:0] next_id34;
    reg [15:0] next_verReg;

    reg wrPend;
    reg [7:0] wrIdx;
    reg [31:0] next_hrdata;
    reg [15:0] readVal;

    wire addrPhase;
    wire wordOk;
    wire inRange;
    wire [7:0] reqIdx;
    wire [19:0] defaultIds;
    wire [19:0] forcedIds;
    wire [31:0] forcedChks;

    assign addrPhase = hsel && hready && htrans[`SLOR_NONSEQ_BIT];
    assign wordOk = (hsize == `SLOR_HSIZE_WORD) && (haddr[1:0] == 2'h0);
    assign inRange = (haddr[31:10] == 22'h000000);
    assign reqIdx = haddr[9:2];

    // Default identifiers
    assign defaultIds = {`SLOR_DEF_ID4, `SLOR_DEF_ID3, `SLOR_DEF_ID2, `SLOR_DEF_ID1};

    // Forced identifier fields
    assign forcedIds = {id34[`SLOR_LO_ID], id34[`SLOR_HI_ID], id12[`SLOR_LO_ID], id12[`SLOR_HI_ID]};

    // Forced checksum fields
    assign forcedChks = {chk34[`SLOR_LO_CHK], chk34[`SLOR_HI_CHK], chk12[`SLOR_LO_CHK], chk12[`SLOR_HI_CHK]};

    // Address phase capture
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wrPend <= 1'b0;
            wrIdx <= 8'h00;
        end
        else if (hready)
        begin
            wrPend <= addrPhase && hwrite && wordOk && inRange;
            wrIdx <= reqIdx;
        end
    end

    // Register write decode
    always @*
    begin
        next_enReg = enReg;
        next_chk12 = chk12;
        next_chk34 = chk34;
        next_id12 = id12;
        next_id34 = id34;
        next_verReg = verReg;
        if (wrPend)
        begin
            case (wrIdx)
                `SLOR_IDX_EN:
                begin
                    next_enReg = hwdata[15:0] & `SLOR_EN_MASK;
                end
                `SLOR_IDX_CHK12:
                begin
                    next_chk12 = hwdata[15:0] & `SLOR_CHK_MASK;
                end
                `SLOR_IDX_CHK34:
                begin
                    next_chk34 = hwdata[15:0] & `SLOR_CHK_MASK;
                end
                `SLOR_IDX_ID12:
                begin
                    next_id12 = hwdata[15:0] & `SLOR_ID_MASK;
                end
                `SLOR_IDX_ID34:
                begin
                    next_id34 = hwdata[15:0] & `SLOR_ID_MASK;
                end
                `SLOR_IDX_VER:
                begin
                    next_verReg = hwdata[15:0] & `SLOR_VER_MASK;
                end
                default:
                begin
                    next_verReg = verReg;
                end
            endcase
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            enReg <= `SLOR_RESET_VAL;
            chk12 <= `SLOR_RESET_VAL;
            chk34 <= `SLOR_RESET_VAL;
            id12 <= `SLOR_RESET_VAL;
            id34 <= `SLOR_RESET_VAL;
            verReg <= `SLOR_RESET_VAL;
        end
        else
        begin
            enReg <= next_enReg;
            chk12 <= next_chk12;
            chk34 <= next_chk34;
            id12 <= next_id12;
            id34 <= next_id34;
            verReg <= next_verReg;
        end
    end

    // Read mux, forwards a write finishing on the same edge
    always @*
    begin
        readVal = 16'h0000;
        case (reqIdx)
            `SLOR_IDX_EN:
            begin
                readVal = next_enReg;
            end
            `SLOR_IDX_CHK12:
            begin
                readVal = next_chk12;
            end
            `SLOR_IDX_CHK34:
            begin
                readVal = next_chk34;
            end
            `SLOR_IDX_ID12:
            begin
                readVal = next_id12;
            end
            `SLOR_IDX_ID34:
            begin
                readVal = next_id34;
            end
            `SLOR_IDX_VER:
            begin
                readVal = next_verReg;
            end
            `SLOR_IDX_STID12:
            begin
                readVal = {3'h0, laneIdent[4:0], 3'h0, laneIdent[9:5]};
            end
            `SLOR_IDX_STID34:
            begin
                readVal = {3'h0, laneIdent[14:10], 3'h0, laneIdent[19:15]};
            end
            `SLOR_IDX_STCHK12:
            begin
                readVal = {laneChk[7:0], laneChk[15:8]};
            end
            `SLOR_IDX_STCHK34:
            begin
                readVal = {laneChk[23:16], laneChk[31:24]};
            end
            `SLOR_IDX_STLINK:
            begin
                readVal = {linkSubclass, 5'h00, linkVersion, 4'h0, versionFault};
            end
            default:
            begin
                readVal = 16'h0000;
            end
        endcase
        if (addrPhase && !hwrite && wordOk && inRange)
        begin
            next_hrdata = {16'h0000, readVal};
        end
        else
        begin
            next_hrdata = 32'h00000000;
        end
    end

    // Zero wait state OKAY answers
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready)
            begin
                hrdata <= next_hrdata;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : lane
            slor_lane_sel u_sel (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .forceId(enReg[`SLOR_IDEN_TOP - i]),
                .forceChk(enReg[`SLOR_CKEN_TOP - i]),
                .defaultId(defaultIds[5*i +: 5]),
                .forcedId(forcedIds[5*i +: 5]),
                .forcedChk(forcedChks[8*i +: 8]),
                .cfgSumBase(cfgSumBase),
                .laneId(laneIdent[5*i +: 5]),
                .laneChk(laneChk[8*i +: 8])
            );
        end
    endgenerate

    slor_ver_dec u_ver (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .unlock(enReg[`SLOR_UNLOCK_BIT]),
        .subclassSel(verReg[`SLOR_SUB_FIELD]),
        .versionSel(verReg[`SLOR_VERS_FIELD]),
        .linkSubclass(linkSubclass),
        .linkVersion(linkVersion),
        .versionFault(versionFault)
    );

endmodule
`default_nettype wire

/* dv/slor_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "slor_map.vh"

module slor_regs_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [7:0] cfgSumBase,
    input wire logic [19:0] laneIdent,
    input wire logic [31:0] laneChk,
    input wire logic [2:0] linkSubclass,
    input wire logic [2:0] linkVersion,
    input wire logic versionFault
);
    logic ap;
    logic [7:0] ai;
    logic [15:0] sh [0:4];
    logic [15:0] vr;
    logic [19:0] eId;
    logic [31:0] eCk;
    logic [15:0] r;
    logic [15:0] c;
    wire okC = vr[15:13] <= 3'h2 && vr[7:5] <= 3'h1;
    wire unl = sh[0][`SLOR_UNLOCK_BIT];
    // Shadow of written registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ap <= 1'b0;
            ai <= 8'h00;
            vr <= 16'h0000;
            for (int i = 0; i < 5; i++) sh[i] <= 16'h0000;
        end
        else
        begin
            ap <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
            ai <= haddr[9:2];
            if (ap && ai[7:3] == 5'h0E && ai[2:0] > 3'h2) sh[ai[2:0] - 3'h3] <= hwdata[15:0];
            if (ap && ai == `SLOR_IDX_VER) vr <= hwdata[15:0];
        end
    end
    // Expected lane values
    always_comb
    begin
        eId = 20'h00000;
        eCk = 32'h00000000;
        for (int l = 0; l < 4; l++)
        begin
            r = sh[3 + l / 2];
            c = sh[1 + l / 2];
            eId[l * 5 +: 5] = sh[0][15 - l] ? (l[0] ? r[4:0] : r[12:8]) : 5'(l + 1);
            eCk[l * 8 +: 8] = sh[0][11 - l] ? (l[0] ? c[7:0] : c[15:8]) : cfgSumBase + eId[l * 5 +: 5];
        end
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_ID12: assert property ($past(rst_n) |-> laneIdent[9:0] == $past(eId[9:0]))
        else $error("lane 1/2 ident wrong");
    AST_ID34: assert property ($past(rst_n) && $stable(eId[19:10]) |-> laneIdent[19:10] == eId[19:10])
        else $error("lane 3/4 ident wrong");
    AST_CK12: assert property ($past(rst_n) |-> laneChk[15:0] == $past(eCk[15:0]))
        else $error("lane 1/2 checksum wrong");
    AST_CK34: assert property ($past(rst_n) |-> laneChk[31:16] == $past(eCk[31:16]))
        else $error("lane 3/4 checksum wrong");
    AST_LOCK: assert property (!unl ##1 !unl |-> linkSubclass == 3'h1 && linkVersion == 3'h1 && !versionFault)
        else $error("locked mode wrong");
    AST_UNLK: assert property (unl && okC ##1 unl && $stable(vr) |-> linkSubclass == vr[15:13] && linkVersion == vr[7:5])
        else $error("unlocked codes not applied");
    AST_FLT: assert property (unl && !okC ##1 unl && $stable(vr) |-> versionFault && linkSubclass == 3'h1)
        else $error("bad code not flagged");
    AST_RST: assert property (disable iff (1'b0) !rst_n |=> laneIdent == 20'h20C41 && laneChk == 32'h00000000)
        else $error("reset outputs wrong");
    cover property (sh[0][15:8] == 8'hFF);
    cover property (unl && okC);
    cover property (versionFault);
endmodule

bind slor_regs slor_regs_sva slor_regs_sva_inst (.*);

`default_nettype wire

/* dv/slor_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none

module slor_rx_model (
    input wire logic ref_clk,
    input wire logic [19:0] laneIdent,
    input wire logic [31:0] laneChk,
    output var logic [19:0] gotId,
    output var logic [31:0] gotChk
);
    // Receiver latches lane config
    always @(posedge ref_clk)
    begin
        gotId <= laneIdent;
        gotChk <= laneChk;
    end
endmodule

`default_nettype wire

/* dv/serial_link_lane_override_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "slor_map.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end

module serial_link_lane_override_regs_test;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] cfgSumBase = 8'h3C;
    logic [31:0] hrdata, rdS, q, laneChk, gotChk;
    logic [19:0] laneIdent, gotId;
    logic [2:0] linkSubclass, linkVersion;
    logic hreadyout, hresp, versionFault, rdyS;
    logic [15:0] en = 16'h0, id12 = 16'h0, id34 = 16'h0, ck12 = 16'h0, ck34 = 16'h0;
    logic [15:0] enTab [11] = '{16'h0000, 16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400,
        16'h0200, 16'h0100, 16'hFF00, 16'hA510};
    int n_mismatch = 0;
    int total_checks = 0;
    slor_regs slor_regs_inst (.*, .hready(hreadyout));
    slor_rx_model slor_rx_model_inst (.*);
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        rdyS <= hreadyout;
        rdS <= hrdata;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic waitRdy();
        int n;
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (rdyS !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        waitRdy();
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        waitRdy();
        q = rdS;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [15:0] e);
        xfer(1'b0, idx, 16'h0);
        `CHK("reg", {16'h0, e}, q)
        `CHK("resp", 1'b0, hresp)
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        xfer(1'b1, idx, d);
        rd(idx, d);
    endtask
    task automatic lanes();
        logic [4:0] i;
        logic [7:0] k;
        logic [15:0] r;
        logic [15:0] c;
        logic [4:0] ei [4];
        logic [7:0] ek [4];
        tick(2);
        for (int l = 0; l < 4; l++)
        begin
            r = l < 2 ? id12 : id34;
            c = l < 2 ? ck12 : ck34;
            i = en[15 - l] ? (l[0] ? r[4:0] : r[12:8]) : 5'(l + 1);
            k = en[11 - l] ? (l[0] ? c[7:0] : c[15:8]) : cfgSumBase + i;
            ei[l] = i;
            ek[l] = k;
            `CHK("ident", i, laneIdent[l * 5 +: 5])
            `CHK("fchk", k, laneChk[l * 8 +: 8])
            `CHK("rx ident", i, gotId[l * 5 +: 5])
            `CHK("rx fchk", k, gotChk[l * 8 +: 8])
        end
        rd(`SLOR_IDX_STID12, {3'h0, ei[0], 3'h0, ei[1]});
        rd(`SLOR_IDX_STID34, {3'h0, ei[2], 3'h0, ei[3]});
        rd(`SLOR_IDX_STCHK12, {ek[0], ek[1]});
        rd(`SLOR_IDX_STCHK34, {ek[2], ek[3]});
    endtask
    initial
    begin
        tick(4);
        rst_n <= 1'b1;
        for (int a = 3; a < 8; a++) rd(8'h70 + a, 16'h0000);
        lanes();
        $display("test reset done");
        id12 = 16'h1A05;
        id34 = 16'h0C17;
        ck12 = 16'hA55A;
        ck34 = 16'h3CF0;
        wr(`SLOR_IDX_ID12, id12);
        wr(`SLOR_IDX_ID34, id34);
        wr(`SLOR_IDX_CHK12, ck12);
        wr(`SLOR_IDX_CHK34, ck34);
        foreach (enTab[j])
        begin
            en = enTab[j];
            cfgSumBase <= cfgSumBase + 8'h61;
            wr(`SLOR_IDX_EN, en);
            lanes();
        end
        $display("test override done");
        en = 16'h0010;
        wr(`SLOR_IDX_EN, en);
        for (int s = 0; s < 3; s++)
            for (int v = 0; v < 2; v++)
            begin
                wr(`SLOR_IDX_VER, {3'(s), 5'h00, 3'(v), 5'h00});
                tick(2);
                `CHK("subclass", 3'(s), linkSubclass)
                `CHK("version", 3'(v), linkVersion)
                `CHK("fault", 1'b0, versionFault)
                rd(`SLOR_IDX_STLINK, {3'(s), 5'h00, 3'(v), 5'h00});
            end
        wr(`SLOR_IDX_VER, 16'h6040);
        tick(2);
        `CHK("bad subclass", 3'h1, linkSubclass)
        `CHK("bad fault", 1'b1, versionFault)
        rd(`SLOR_IDX_STLINK, 16'h2021);
        wr(`SLOR_IDX_VER, 16'h0000);
        en = 16'h0000;
        wr(`SLOR_IDX_EN, en);
        tick(2);
        `CHK("locked sub", 3'h1, linkSubclass)
        `CHK("locked ver", 3'h1, linkVersion)
        $display("test version done");
        xfer(1'b1, 8'h10, 16'h0000);
        rd(8'h10, 16'h0000);
        $display("test unmapped done");
        en = 16'hFF00;
        wr(`SLOR_IDX_EN, en);
        rst_n <= 1'b0;
        tick(4);
        rst_n <= 1'b1;
        {en, id12, id34, ck12, ck34} = 80'h0;
        for (int a = 3; a < 8; a++) rd(8'h70 + a, 16'h0000);
        lanes();
        $display("test second reset done");
        summarize();
    end
endmodule

`default_nettype wire
